// ==== hw/status_bank.sv ====
// status structure register bank: event and enable registers, error queue
// count, enable-value programming and formatted register queries
// assumes a controller issuing one decoded command at a time on cmd_*,
// parameter characters on param_*, and draining responses on resp_*
//
// Behaviour
// - power-up clears all status registers; output and error queues empty
// - writing zero to an enable register clears every bit of it
// - system preset and reset commands leave registers and queues alone
// - clear-status zeroes standard, operation, measurement, questionable events
// - status preset zeroes operation, measurement, questionable enable registers
// - standard event enable changes only through its own write
// - clear-status also empties the error queue
// - status preset leaves the error queue untouched
// - queue-clear and error-clear commands both empty the error queue
// - only enable registers accept writes; others are read-only
// - sixteen bits, bit n weighs two to the n, up to 32768
// - non-decimal values carry #B, #H or #Q radix prefix
// - radix prefix letter accepted in either case
// - unprefixed numeric values are decimal
// - digits must be valid for the selected radix
// - every register readable by query, value shows set bits
// - read format selects decimal, hexadecimal, octal or binary
// - non-decimal responses carry #B, #H or #Q header
`timescale 1ns/1ns

module status_bank
  import status_pkg::*;
#(
  parameter int ERRQ_DEPTH = 10,
  parameter int ERRQ_W     = $clog2(ERRQ_DEPTH + 1)
)(
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire logic              cmd_valid,
  input  wire cmd_t              cmd_code,
  input  wire sel_t              cmd_sel,
  input  wire fmt_t              cmd_fmt,
  output logic                   cmd_ready,
  input  wire logic              param_valid,
  input  wire logic [7:0]        param_char,
  input  wire logic              param_last,
  output logic                   param_ready,
  input  wire logic [REG_W-1:0]  std_set,
  input  wire logic [REG_W-1:0]  oper_set,
  input  wire logic [REG_W-1:0]  meas_set,
  input  wire logic [REG_W-1:0]  ques_set,
  input  wire logic [REG_W-1:0]  oper_cond,
  input  wire logic [REG_W-1:0]  meas_cond,
  input  wire logic [REG_W-1:0]  ques_cond,
  input  wire logic              err_push,
  input  wire logic              err_pop,
  output logic                   resp_valid,
  output logic [7:0]             resp_char,
  output logic                   resp_last,
  input  wire logic              resp_ready,
  output logic [3:0]             summary,
  output logic [ERRQ_W-1:0]      err_count,
  output logic                   cmd_error
);

  typedef enum logic [1:0] {PH_IDLE, PH_PARSE, PH_EMIT} phase_t;

  typedef struct packed {
    logic [REG_W-1:0]  std_ev;
    logic [REG_W-1:0]  oper_ev;
    logic [REG_W-1:0]  meas_ev;
    logic [REG_W-1:0]  ques_ev;
    logic [REG_W-1:0]  std_en;
    logic [REG_W-1:0]  oper_en;
    logic [REG_W-1:0]  meas_en;
    logic [REG_W-1:0]  ques_en;
    fmt_t              fmt;
    logic [ERRQ_W-1:0] err_cnt;
    phase_t            phase;
    sel_t              tgt;
    logic              got_last;
    logic [BCD_W-1:0]  shift;
    logic [4:0]        ndig;
    logic [2:0]        dw;
    logic [1:0]        hdr;
    logic [7:0]        letter;
    logic              started;
    logic              cmd_ready;
    logic              param_ready;
    logic              resp_valid;
    logic [7:0]        resp_char;
    logic              resp_last;
    logic [3:0]        summary;
    logic              cmd_error;
  } st_t;

  st_t s_q, s_d;

  logic             take;
  logic             p_start;
  logic             p_done;
  logic             p_err;
  logic [REG_W-1:0] p_value;
  logic             push_int;
  logic             clr_q;
  logic [REG_W-1:0] rd_val;
  logic [3:0]       digit;
  logic [ERRQ_W+1:0] cnt;

  // ==========================================================================
  // helpers
  function automatic logic is_enable(input sel_t sel);
    is_enable = (sel == SEL_STD_EN) || (sel == SEL_OPER_EN) ||
                (sel == SEL_MEAS_EN) || (sel == SEL_QUES_EN);
  endfunction

  function automatic logic [BCD_W-1:0] to_bcd(input logic [REG_W-1:0] v);
    logic [BCD_W-1:0] b;
    b = '0;
    for (int i = REG_W - 1; i >= 0; i--) begin
      for (int k = 0; k < 5; k++) begin
        if (b[4*k +: 4] > 4'h4) begin
          b[4*k +: 4] = 4'(b[4*k +: 4] + 4'h3);
        end
      end
      b = {b[BCD_W-2:0], v[i]};
    end
    to_bcd = b;
  endfunction

  // ==========================================================================
  // parameter parser
  param_parser u_parser (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .start      (p_start),
    .char_valid (param_valid & s_q.param_ready),
    .char_data  (param_char),
    .char_last  (param_last),
    .done       (p_done),
    .error      (p_err),
    .value      (p_value)
  );

  assign take = cmd_valid & s_q.cmd_ready;

  // ==========================================================================
  // register read mux
  always_comb begin
    case (cmd_sel)
      SEL_STD_EV:    rd_val = s_q.std_ev;
      SEL_STD_EN:    rd_val = s_q.std_en;
      SEL_OPER_COND: rd_val = oper_cond;
      SEL_OPER_EV:   rd_val = s_q.oper_ev;
      SEL_OPER_EN:   rd_val = s_q.oper_en;
      SEL_MEAS_COND: rd_val = meas_cond;
      SEL_MEAS_EV:   rd_val = s_q.meas_ev;
      SEL_MEAS_EN:   rd_val = s_q.meas_en;
      SEL_QUES_COND: rd_val = ques_cond;
      SEL_QUES_EV:   rd_val = s_q.ques_ev;
      default:       rd_val = s_q.ques_en;
    endcase
  end

  // ==========================================================================
  // next state
  always_comb begin
    s_d           = s_q;
    s_d.cmd_error = 1'b0;
    p_start       = 1'b0;
    push_int      = 1'b0;
    clr_q         = 1'b0;
    digit         = 4'h0;
    cnt           = '0;
    case (s_q.phase)
      PH_IDLE: begin
        if (take) begin
          case (cmd_code)
            CMD_CLS: begin
              s_d.std_ev  = REG_RST;
              s_d.oper_ev = REG_RST;
              s_d.meas_ev = REG_RST;
              s_d.ques_ev = REG_RST;
              clr_q       = 1'b1;
            end
            CMD_STAT_PRESET: begin
              // standard enable and error queue kept on purpose
              s_d.oper_en = REG_RST;
              s_d.meas_en = REG_RST;
              s_d.ques_en = REG_RST;
            end
            CMD_QUE_CLEAR, CMD_ERR_CLEAR: clr_q = 1'b1;
            CMD_SET_FORMAT: s_d.fmt = cmd_fmt;
            CMD_WRITE: begin
              s_d.tgt         = cmd_sel;
              s_d.phase       = PH_PARSE;
              s_d.got_last    = 1'b0;
              s_d.param_ready = 1'b1;
              p_start         = 1'b1;
            end
            CMD_QUERY: begin
              s_d.phase   = PH_EMIT;
              s_d.started = 1'b0;
              s_d.hdr     = 2'h0;
              case (s_q.fmt)
                FMT_HEX: begin
                  s_d.shift  = {rd_val, 4'h0};
                  s_d.ndig   = ND_HEX;
                  s_d.dw     = DW_HEX;
                  s_d.letter = CH_H;
                end
                FMT_OCT: begin
                  s_d.shift  = {2'b00, rd_val, 2'b00};
                  s_d.ndig   = ND_OCT;
                  s_d.dw     = DW_OCT;
                  s_d.letter = CH_Q;
                end
                FMT_BIN: begin
                  s_d.shift  = {rd_val, 4'h0};
                  s_d.ndig   = ND_BIN;
                  s_d.dw     = DW_BIN;
                  s_d.letter = CH_B;
                end
                default: begin
                  s_d.shift  = to_bcd(rd_val);
                  s_d.ndig   = ND_DEC;
                  s_d.dw     = DW_HEX;
                  s_d.letter = CH_HASH;
                  s_d.hdr    = HDR_DONE;
                end
              endcase
              // event registers clear when read
              if (cmd_sel == SEL_STD_EV)  s_d.std_ev  = REG_RST;
              if (cmd_sel == SEL_OPER_EV) s_d.oper_ev = REG_RST;
              if (cmd_sel == SEL_MEAS_EV) s_d.meas_ev = REG_RST;
              if (cmd_sel == SEL_QUES_EV) s_d.ques_ev = REG_RST;
            end
            default: ;
          endcase
        end
      end
      PH_PARSE: begin
        if (param_valid && s_q.param_ready && param_last) begin
          s_d.got_last    = 1'b1;
          s_d.param_ready = 1'b0;
        end
        if (p_done) begin
          s_d.phase = PH_IDLE;
          if (p_err || !is_enable(s_q.tgt)) begin
            push_int      = 1'b1;
            s_d.cmd_error = 1'b1;
          end else begin
            case (s_q.tgt)
              SEL_STD_EN:  s_d.std_en  = p_value;
              SEL_OPER_EN: s_d.oper_en = p_value;
              SEL_MEAS_EN: s_d.meas_en = p_value;
              default:     s_d.ques_en = p_value;
            endcase
          end
        end
      end
      default: begin
        if (!s_q.resp_valid || resp_ready) begin
          s_d.resp_valid = 1'b0;
          if (s_q.resp_valid && s_q.resp_last) begin
            s_d.phase = PH_IDLE;
          end else if (s_q.hdr != HDR_DONE) begin
            s_d.resp_valid = 1'b1;
            s_d.resp_last  = 1'b0;
            s_d.resp_char  = (s_q.hdr == 2'h0) ? CH_HASH : s_q.letter;
            s_d.hdr        = 2'(s_q.hdr + 2'h1);
          end else begin
            case (s_q.dw)
              DW_BIN:  digit = {3'b000, s_q.shift[BCD_W-1]};
              DW_OCT:  digit = {1'b0, s_q.shift[BCD_W-1 -: 3]};
              default: digit = s_q.shift[BCD_W-1 -: 4];
            endcase
            // leading zeros dropped, a lone zero still sent
            if (digit != 4'h0 || s_q.started || s_q.ndig == 5'h01) begin
              s_d.resp_valid = 1'b1;
              s_d.resp_last  = (s_q.ndig == 5'h01);
              s_d.resp_char  = (digit < 4'hA) ? (CH_0 + 8'(digit)) :
                                                (CH_A + 8'(digit) - 8'h0A);
            end
            s_d.started = s_q.started | (digit != 4'h0);
            s_d.shift   = s_q.shift << s_q.dw;
            s_d.ndig    = 5'(s_q.ndig - 5'h01);
          end
        end
      end
    endcase
    // hardware sets win over every clear above
    s_d.std_ev  = s_d.std_ev | std_set;
    s_d.oper_ev = s_d.oper_ev | oper_set;
    s_d.meas_ev = s_d.meas_ev | meas_set;
    s_d.ques_ev = s_d.ques_ev | ques_set;
    cnt = (clr_q ? '0 : (ERRQ_W+2)'(s_q.err_cnt));
    if (err_pop && cnt != '0 && !clr_q) begin
      cnt = (ERRQ_W+2)'(cnt - 1'b1);
    end
    cnt = (ERRQ_W+2)'(cnt + err_push + push_int);
    s_d.err_cnt = (cnt > (ERRQ_W+2)'(ERRQ_DEPTH)) ? ERRQ_W'(ERRQ_DEPTH) :
                                                     cnt[ERRQ_W-1:0];
    s_d.summary = {|(s_d.ques_ev & s_d.ques_en), |(s_d.meas_ev & s_d.meas_en),
                   |(s_d.oper_ev & s_d.oper_en), |(s_d.std_ev & s_d.std_en)};
    s_d.cmd_ready = (s_d.phase == PH_IDLE);
  end

  // power-up clears everything and selects decimal responses
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cmd_ready   = s_q.cmd_ready;
  assign param_ready = s_q.param_ready;
  assign resp_valid  = s_q.resp_valid;
  assign resp_char   = s_q.resp_char;
  assign resp_last   = s_q.resp_last;
  assign summary     = s_q.summary;
  assign err_count   = s_q.err_cnt;
  assign cmd_error   = s_q.cmd_error;

  // ==========================================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  AST_POWER_UP: assert property ($rose(reset_n) |->
    (s_q.std_en == REG_RST && s_q.err_cnt == '0 && !resp_valid))
    else $error("state not clear after power-up");
  AST_FMT_DEFAULT: assert property ($rose(reset_n) |->
    (s_q.fmt == FMT_ASCII)) else $error("format not decimal after power-up");
  AST_ZERO_CLEARS: assert property ((s_q.phase == PH_PARSE && p_done &&
    !p_err && p_value == REG_RST && s_q.tgt == SEL_MEAS_EN) |=>
    s_q.meas_en == REG_RST) else $error("zero write did not clear enable");
  AST_PRESET_NOP: assert property ((take && (cmd_code == CMD_SYS_PRESET ||
    cmd_code == CMD_RST)) |=> ($stable(s_q.std_en) && $stable(s_q.oper_en) &&
    $stable(s_q.ques_en) && (($past(s_q.std_ev) & ~s_q.std_ev) == '0)))
    else $error("preset command changed status registers");
  AST_CLS_EVENTS: assert property ((take && cmd_code == CMD_CLS) |=>
    ((s_q.oper_ev & ~$past(oper_set)) == '0 &&
     (s_q.meas_ev & ~$past(meas_set)) == '0 &&
     (s_q.std_ev & ~$past(std_set)) == '0 &&
     (s_q.ques_ev & ~$past(ques_set)) == '0))
    else $error("clear-status left event bits");
  AST_STAT_PRESET: assert property ((take && cmd_code == CMD_STAT_PRESET) |=>
    (s_q.oper_en == '0 && s_q.meas_en == '0 && $stable(s_q.std_en) &&
     s_q.ques_en == '0 &&
     ($past(s_q.err_cnt) < 2 || s_q.err_cnt != '0)))
    else $error("status preset wrong effect");
  AST_QUEUE_CLEAR: assert property ((take && (cmd_code == CMD_CLS ||
    cmd_code == CMD_QUE_CLEAR || cmd_code == CMD_ERR_CLEAR)) |=>
    s_q.err_cnt <= 1) else $error("error queue not emptied");
  AST_READ_ONLY: assert property (1'b1 |=>
    ((s_q.std_ev & ~$past(s_q.std_ev) & ~$past(std_set)) == '0))
    else $error("event register gained a bit without an event");
  AST_BAD_PARAM: assert property ((s_q.phase == PH_PARSE && p_done &&
    p_err) |=> ($stable(s_q.std_en) && $stable(s_q.oper_en) && cmd_error))
    else $error("bad parameter changed a register");
  AST_HEADER: assert property ((take && cmd_code == CMD_QUERY &&
    s_q.fmt != FMT_ASCII) |-> ##2 (resp_valid && resp_char == CH_HASH))
    else $error("non-decimal response lacks header");

  COV_CLS:   cover property (take && cmd_code == CMD_CLS);
  COV_HEX:   cover property (take && cmd_code == CMD_QUERY &&
                             s_q.fmt == FMT_HEX);
  COV_WRITE: cover property (s_q.phase == PH_PARSE && p_done && !p_err);

endmodule // status_bank

// ==== hw/status_pkg.sv ====
// status structure package: widths, characters, reset values, enumerations
// assumes ascii command characters and a 16-bit status structure
package status_pkg;

  // ==========================================================================
  // widths and reset values
  localparam int          REG_W      = 16;
  localparam int          BCD_W      = 20;
  localparam logic [15:0] REG_RST    = 16'h0000;
  localparam logic [15:0] REG_MAX    = 16'hFFFF;

  // ==========================================================================
  // characters of parameters and responses
  localparam logic [7:0]  CH_HASH    = 8'h23;
  localparam logic [7:0]  CH_0       = 8'h30;
  localparam logic [7:0]  CH_9       = 8'h39;
  localparam logic [7:0]  CH_A       = 8'h41;
  localparam logic [7:0]  CH_F       = 8'h46;
  localparam logic [7:0]  CH_B       = 8'h42;
  localparam logic [7:0]  CH_H       = 8'h48;
  localparam logic [7:0]  CH_Q       = 8'h51;
  localparam logic [7:0]  CH_CASE    = 8'h20;
  localparam logic [7:0]  CH_LOW_A   = 8'h61;
  localparam logic [7:0]  CH_LOW_Z   = 8'h7A;
  localparam logic [4:0]  DIG_BAD    = 5'h1F;

  // ==========================================================================
  // response digit layout per format
  localparam logic [2:0]  DW_BIN     = 3'h1;
  localparam logic [2:0]  DW_OCT     = 3'h3;
  localparam logic [2:0]  DW_HEX     = 3'h4;
  localparam logic [4:0]  ND_BIN     = 5'h10;
  localparam logic [4:0]  ND_OCT     = 5'h06;
  localparam logic [4:0]  ND_HEX     = 5'h04;
  localparam logic [4:0]  ND_DEC     = 5'h05;
  localparam logic [1:0]  HDR_DONE   = 2'h2;

  // ==========================================================================
  // enumerations
  typedef enum logic [1:0] {FMT_ASCII, FMT_HEX, FMT_OCT, FMT_BIN} fmt_t;

  typedef enum logic [3:0] {
    CMD_CLS, CMD_STAT_PRESET, CMD_SYS_PRESET, CMD_RST, CMD_QUE_CLEAR,
    CMD_ERR_CLEAR, CMD_SET_FORMAT, CMD_WRITE, CMD_QUERY
  } cmd_t;

  typedef enum logic [3:0] {
    SEL_STD_EV, SEL_STD_EN, SEL_OPER_COND, SEL_OPER_EV, SEL_OPER_EN,
    SEL_MEAS_COND, SEL_MEAS_EV, SEL_MEAS_EN, SEL_QUES_COND, SEL_QUES_EV,
    SEL_QUES_EN
  } sel_t;

  // ==========================================================================
  // shared helpers
  function automatic logic [7:0] upcase(input logic [7:0] c);
    upcase = (c >= CH_LOW_A && c <= CH_LOW_Z) ? (c & ~CH_CASE) : c;
  endfunction

  function automatic logic [4:0] radix_base(input fmt_t f);
    case (f)
      FMT_BIN: radix_base = 5'h02;
      FMT_OCT: radix_base = 5'h08;
      FMT_HEX: radix_base = 5'h10;
      default: radix_base = 5'h0A;
    endcase
  endfunction

endpackage

// ==== hw/param_parser.sv ====
// enable-value parser: turns a character stream into a 16-bit value
// assumes characters arrive one per cycle, the last one flagged
`timescale 1ns/1ns

module param_parser
  import status_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        start,
  input  wire logic        char_valid,
  input  wire logic [7:0]  char_data,
  input  wire logic        char_last,
  output logic             done,
  output logic             error,
  output logic [REG_W-1:0] value
);

  typedef enum logic [1:0] {P_FIRST, P_LETTER, P_DIGITS} pos_t;

  typedef struct packed {
    pos_t             pos;
    fmt_t             radix;
    logic [REG_W-1:0] acc;
    logic             seen;
    logic             err;
    logic             done;
    logic             error;
    logic [REG_W-1:0] value;
  } pst_t;

  pst_t s_q, s_d;
  logic [7:0]  c;
  logic [4:0]  dval;
  logic [23:0] grown;
  logic        do_digit;

  // ==========================================================================
  // next state
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    c        = upcase(char_data);
    dval     = DIG_BAD;
    grown    = 24'h000000;
    do_digit = 1'b0;
    if (start) begin
      s_d = '0;
    end else if (char_valid) begin
      case (s_q.pos)
        P_FIRST: begin
          s_d.pos = P_DIGITS;
          if (c == CH_HASH) begin
            s_d.pos = P_LETTER;
          end else begin
            s_d.radix = FMT_ASCII;
            do_digit  = 1'b1;
          end
        end
        P_LETTER: begin
          s_d.pos = P_DIGITS;
          if (c == CH_B) begin
            s_d.radix = FMT_BIN;
          end else if (c == CH_H) begin
            s_d.radix = FMT_HEX;
          end else if (c == CH_Q) begin
            s_d.radix = FMT_OCT;
          end else begin
            s_d.err = 1'b1;
          end
        end
        default: do_digit = 1'b1;
      endcase
      if (do_digit) begin
        if (c >= CH_0 && c <= CH_9) begin
          dval = 5'(c - CH_0);
        end else if (c >= CH_A && c <= CH_F) begin
          dval = 5'(c - CH_A + 8'h0A);
        end
        grown = 24'(s_q.acc) * 24'(radix_base(s_d.radix)) + 24'(dval);
        if (dval >= radix_base(s_d.radix)) begin
          s_d.err = 1'b1;
        end else if (grown > 24'(REG_MAX)) begin
          s_d.err = 1'b1;
        end else begin
          s_d.acc  = grown[REG_W-1:0];
          s_d.seen = 1'b1;
        end
      end
      if (char_last) begin
        s_d.done  = 1'b1;
        s_d.error = s_d.err | ~s_d.seen;
        s_d.value = s_d.acc;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done  = s_q.done;
  assign error = s_q.error;
  assign value = s_q.value;

  // ==========================================================================
  // checks
  AST_BAD_BIN_DIGIT: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!start && char_valid && char_last && s_q.pos == P_DIGITS &&
     s_q.radix == FMT_BIN && char_data == 8'h32) |=> (done && error))
    else $error("binary digit two not refused");

endmodule // param_parser

// ==== verification/ctrl_model.sv ====
// controller model: commands, parameter text, response drain
// assumes requests are sampled on the rising core_clk edge
`timescale 1ns/1ns

module ctrl_model
  import status_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       cmd_ready,
  input  wire logic       param_ready,
  input  wire logic       resp_valid,
  input  wire logic [7:0] resp_char,
  input  wire logic       resp_last,
  output logic            cmd_valid = 1'b0,
  output cmd_t            cmd_code = CMD_RST,
  output sel_t            cmd_sel = SEL_STD_EV,
  output fmt_t            cmd_fmt = FMT_ASCII,
  output logic            param_valid = 1'b0,
  output logic [7:0]      param_char = 8'h00,
  output logic            param_last = 1'b0,
  output logic            resp_ready = 1'b0
);
  bit slow = 1'b0;
  // ==========
  // requests
  task automatic issue(input cmd_t c, input sel_t s, input fmt_t f);
    cmd_code = c;
    cmd_sel = s;
    cmd_fmt = f;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) @(posedge core_clk) #1;
    @(posedge core_clk) #1;
    cmd_valid = 1'b0;
  endtask
  // prefix, if any, and digits go out as given, msb first
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      param_char = s[i];
      param_last = (i == s.len() - 1);
      param_valid = 1'b1;
      while (param_ready !== 1'b1) @(posedge core_clk) #1;
      @(posedge core_clk) #1;
    end
    param_valid = 1'b0;
    // released lines must not keep showing the last character
    param_char = ~param_char;
  endtask
  task automatic fetch(output string r);
    r = "";
    for (int n = 0; n < 300; n++) begin
      resp_ready = !(slow && n[0]);
      if (resp_valid === 1'b1 && resp_ready) begin
        r = {r, string'(resp_char)};
        if (resp_last === 1'b1) n = 300;
      end
      @(posedge core_clk) #1;
    end
    resp_ready = 1'b0;
  endtask
endmodule // ctrl_model

// ==== verification/tb_top.sv ====
// self-checking bench for the status bank
// assumes ctrl_model drives the command side
`timescale 1ns/1ns

module tb_top;
  import status_pkg::*;
  logic             core_clk = 1'b0, reset_n = 1'b0;
  logic [REG_W-1:0] std_set = '0, oper_set = '0, meas_set = '0;
  logic [REG_W-1:0] ques_set = '0, oper_cond = '0;
  logic [REG_W-1:0] meas_cond = '0, ques_cond = '0;
  logic             err_push = 1'b0, err_pop = 1'b0;
  logic             cmd_valid, param_valid, param_last, resp_ready;
  logic             cmd_ready, param_ready, resp_valid, resp_last;
  logic             cmd_error;
  logic [7:0]       param_char, resp_char;
  logic [3:0]       summary, err_count;
  cmd_t             cmd_code;
  sel_t             cmd_sel;
  fmt_t             cmd_fmt;
  int               miscompares = 0, comparisons = 0, cycles = 0, errs = 0;
  string            r;
  string forms [6] = '{"#b101100", "#h2C", "#q54", "44", "#B101100", "#Q54"};
  string fmtx [4] = '{"26", "#H1A", "#Q32", "#B11010"};
  sel_t  ens [4] = '{SEL_STD_EN, SEL_OPER_EN, SEL_MEAS_EN, SEL_QUES_EN};

  status_bank DUT (.*);
  ctrl_model u_ctrl (.*);

  always #5 core_clk = ~core_clk;
  always @(negedge core_clk) errs += (cmd_error === 1'b1);
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end
  // ==========
  // helpers
  task automatic check(input bit ok, input string m);
    comparisons++;
    if (!ok) begin
      miscompares++;
      $display("BAD at %0t: %s", $time, m);
    end
  endtask
  task automatic peek(input sel_t s, input string e);
    u_ctrl.issue(CMD_QUERY, s, FMT_ASCII);
    u_ctrl.fetch(r);
    check(r == e, {"read ", r, " want ", e});
  endtask
  task automatic put(input sel_t s, input string v);
    u_ctrl.issue(CMD_WRITE, s, FMT_ASCII);
    u_ctrl.send(v);
  endtask
  task automatic order(input cmd_t c);
    u_ctrl.issue(c, SEL_STD_EV, FMT_ASCII);
    #20;
  endtask
  task automatic kick(input logic [3:0] m, input logic p);
    {ques_set[0], meas_set[0], oper_set[0], std_set[0]} = m;
    err_push = p;
    @(posedge core_clk) #1;
    {ques_set[0], meas_set[0], oper_set[0], std_set[0]} = 4'h0;
    err_push = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic test_parse();
    foreach (forms[i]) begin
      put(SEL_MEAS_EN, "0");
      peek(SEL_MEAS_EN, "0");
      put(SEL_MEAS_EN, forms[i]);
      peek(SEL_MEAS_EN, "44");
    end
    put(SEL_QUES_EN, "65535");
    peek(SEL_QUES_EN, "65535");
    put(SEL_QUES_EN, "#h8000");
    peek(SEL_QUES_EN, "32768");
    put(SEL_QUES_EN, "#q58");
    put(SEL_QUES_EN, "#b102");
    put(SEL_OPER_EV, "1");
    peek(SEL_QUES_EN, "32768");
    check(errs == 3 && err_count === 4'h3, "refusals");
    order(CMD_QUE_CLEAR);
    check(err_count === 4'h0, "queue clear");
    kick(4'h0, 1'b1);
    order(CMD_ERR_CLEAR);
    check(err_count === 4'h0, "error clear");
    $display("test parse done");
  endtask
  task automatic test_format();
    put(SEL_OPER_EN, "26");
    u_ctrl.slow = 1'b1;
    foreach (fmtx[i]) begin
      u_ctrl.issue(CMD_SET_FORMAT, SEL_STD_EV, fmt_t'(i));
      @(posedge core_clk) #1;
      peek(SEL_OPER_EN, fmtx[i]);
    end
    oper_cond = 16'h00A5;
    peek(SEL_OPER_COND, "#B10100101");
    order(CMD_SET_FORMAT);
    u_ctrl.slow = 1'b0;
    $display("test format done");
  endtask
  task automatic test_clear();
    foreach (ens[i]) put(ens[i], "1");
    kick(4'hF, 1'b1);
    kick(4'h0, 1'b1);
    check(summary === 4'hF && err_count === 4'h2, "events latched");
    order(CMD_SYS_PRESET);
    order(CMD_RST);
    check(summary === 4'hF && err_count === 4'h2, "presets");
    order(CMD_STAT_PRESET);
    check(summary === 4'h1 && err_count === 4'h2, "stat");
    order(CMD_CLS);
    check(summary === 4'h0 && err_count === 4'h0, "clear");
    kick(4'h1, 1'b0);
    check(summary === 4'h1, "std enable kept");
    put(SEL_STD_EN, "0");
    peek(SEL_STD_EN, "0");
    check(summary === 4'h0, "std enable zero");
    $display("test clear done");
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    #1 reset_n = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    check(cmd_ready === 1'b1 && err_count === 4'h0, "power-up");
    for (int i = 0; i < 11; i++) peek(sel_t'(i), "0");
    $display("test reset done");
    test_parse();
    test_format();
    test_clear();
    conclude();
  end
endmodule // tb_top
